/* File: common/smaer_flag_if.sv */
// Purpose: carries sticky flag set, clear and state between modules
// Assumes: one owner module holds the flags
// Notes:   vectors are indexed by flag position
`timescale 1ns/1ps
interface smaer_flag_if #(parameter int unsigned N = 1);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flag;
   modport owner (input set, input clr, output flag);
   modport user  (output set, output clr, input flag);
endinterface

/* File: common/smaer_pkg.sv */
// Purpose: shared constants of the platform event router
// Assumes: 50 MHz pclk, APB register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package smaer_pkg;

   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned ESPI_HOLD_NS  = 100000;  // 100 us
   localparam int unsigned ESPI_HOLD_CYC =
      (ESPI_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PROT   = 8'h0C;
   localparam logic [7:0] OFS_DATAIN = 8'h10;

   // ----------------------------------------------------------
   // flag positions in status and enable
   // ----------------------------------------------------------
   localparam int unsigned NFLAG  = 11;
   localparam int unsigned F_TMR  = 0;
   localparam int unsigned F_APM  = 1;
   localparam int unsigned F_INTR = 2;
   localparam int unsigned F_FWW  = 3;
   localparam int unsigned F_PIN  = 4;
   localparam int unsigned F_OSW  = 5;
   localparam int unsigned F_WDG  = 6;
   localparam int unsigned F_NMI  = 7;
   localparam int unsigned F_GREL = 8;
   localparam int unsigned F_BTN  = 9;
   localparam int unsigned F_ESPI = 10;
   localparam logic [10:0] EN_MASK = 11'h597;  // timer wrap enable too
   localparam int unsigned EN_ISEL = 12;      // 2-bit field

   // ----------------------------------------------------------
   // control and protect fields, reset values
   // ----------------------------------------------------------
   localparam int unsigned C_MODE  = 0;
   localparam int unsigned C_GMGMT = 1;
   localparam int unsigned C_REARM = 2;
   localparam int unsigned C_FWREL = 3;
   localparam int unsigned C_APIC  = 4;
   localparam int unsigned C_LINE  = 8;       // 3-bit field
   localparam int unsigned P_WPD   = 0;
   localparam int unsigned P_LOCK  = 1;
   localparam int unsigned P_GLK   = 2;
   localparam logic [1:0] ISEL_MGMT   = 2'h2;
   localparam logic [2:0] LINE_MAX    = 3'h6;
   localparam logic [2:0] LINE_LOWTOP = 3'h2;
   localparam logic       REARM_RST   = 1'h1;

   // message sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } smaer_msg_t;

endpackage

/* File: design/smaer_flags.sv */
// Purpose: bank of sticky status flags, write-one-to-clear
// Assumes: set is a one-cycle event, clr comes from a bus write
// Notes:   an event in the clearing cycle keeps the flag set
`timescale 1ns/1ps
module smaer_flags #(parameter int unsigned N = 1)
(
   input wire logic   pclk,
   input wire logic   presetn,
   smaer_flag_if.owner fl
);

   // ----------------------------------------------------------
   // flag storage
   // ----------------------------------------------------------
   logic [N-1:0] flag_reg;

   // set wins so no event is lost during a clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_reg <= '0;
      else
         flag_reg <= (flag_reg & ~fl.clr) | fl.set;
   end

   assign fl.flag = flag_reg;

   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (fl.set != '0) |=> ((fl.flag & $past(fl.set)) == $past(fl.set)))
      else $error("event lost against a clear");
   a_clr_only_one: assert property (@(posedge pclk) disable iff (!presetn)
      (fl.clr == '0 && fl.set == '0) |=> $stable(fl.flag))
      else $error("flag moved without a cause");

endmodule

/* File: design/smaer_top.sv */
// Purpose: routes platform events to the ACPI level interrupt and
//          to management interrupt messages for the processor
// Assumes: event inputs synchronous to pclk, APB slave, no wait
// Notes:   pready is always high; reads sample at the setup cycle
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - every source has its own sticky status flag; firmware-write, OS-write, watchdog and button have no enable bit
// - dual sources go to one output, chosen by the software mode bit
// - ACPI interrupt needs ACPI mode set, except the release event
// - dual sources reach the management path only with mode clear
// - no management interrupt unless the global enable is set
// - ACPI line is 9..11, or 20..23 only in APIC mode
// - button override sets its flag, ACPI only, no enable bit
// - override requests S5 at once; flag interrupts later under mode
// - global release flag asserts ACPI interrupt even with mode clear
// - timer wrap sets its flag and, if enabled, one of the outputs
// - APM port write sets its flag, management irq if enabled
// - intrusion sets its flag, management irq when select is 10
// - unprotect 0 to 1 while locked sets firmware-write flag
// - firmware write attempt while protected sets firmware-write flag
// - lockdown 1 to 0 sets pin-unlock flag, irq if enabled
// - OS data-in write sets its flag and signals management if the global enable is set
// - redirected NMI sets watchdog and redirect flags, management irq
// - firmware release write sets global release flag, ACPI only
// - enabled event with re-arm set clears re-arm, sends one message
// - ACPI interrupt is a level held while enabled flags remain
module smaer_top
   import smaer_pkg::*;
#(
   parameter int unsigned ESPI_HOLD = smaer_pkg::ESPI_HOLD_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pm_timer_wrap,
   input  wire logic        apm_port_write,
   input  wire logic        intrusion_in,
   input  wire logic        flash_write_attempt,
   input  wire logic        nmi_event,
   input  wire logic        button_override,
   input  wire logic        espi_acpi_req,
   output logic             acpi_event_irq,
   output logic [6:0]       acpi_irq_lines,
   output logic             mgmt_mode_irq,
   input  wire logic        virtual_wire_message_ready,
   output logic             s5_entry_req
);
   import smaer_pkg::*;

   // ----------------------------------------------------------
   // declarations
   // ----------------------------------------------------------
   logic             acpi_mode_reg;
   logic             gmgmt_en_reg;
   logic             rearm_reg;
   logic             apic_reg;
   logic [2:0]       line_sel_reg;
   logic [NFLAG-1:0] en_reg;
   logic [1:0]       isel_reg;
   logic             wpd_reg;
   logic             lock_reg;
   logic             glk_reg;
   logic [7:0]       data_in_reg;
   logic             intr_prev_reg;
   logic [15:0]      espi_cnt_reg;
   logic [31:0]      prdata_reg;
   logic             pslverr_reg;
   logic             acpi_irq_reg;
   logic [6:0]       lines_reg;
   logic             s5_reg;
   smaer_msg_t       st_reg;
   smaer_msg_t       st_next;

   logic             wr_acc;
   logic             wr_ctrl;
   logic             wr_en;
   logic             wr_stat;
   logic             wr_prot;
   logic             wr_data;
   logic             espi_hit;
   logic             fw_event;
   logic             pin_event;
   logic             nmi_hit;
   logic [NFLAG-1:0] acpi_mask;
   logic [NFLAG-1:0] mgmt_mask;
   logic             acpi_level;
   logic             mgmt_src;
   logic             trigger;
   logic [2:0]       line_idx;

   smaer_flag_if #(.N(NFLAG)) fl ();

   smaer_flags #(.N(NFLAG)) u_flags
   (
      .pclk    (pclk),
      .presetn (presetn),
      .fl      (fl)
   );

   // ----------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------
   // zero wait states keep the access phase to one cycle
   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign wr_ctrl = wr_acc & (paddr == OFS_CTRL);
   assign wr_en   = wr_acc & (paddr == OFS_ENABLE);
   assign wr_stat = wr_acc & (paddr == OFS_STATUS);
   assign wr_prot = wr_acc & (paddr == OFS_PROT);
   assign wr_data = wr_acc & (paddr == OFS_DATAIN);

   // read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         case (paddr)
            OFS_CTRL:
               prdata_reg <= {21'h0, line_sel_reg, 3'h0, apic_reg,
                              1'b0, rearm_reg, gmgmt_en_reg,
                              acpi_mode_reg};
            OFS_ENABLE:
               prdata_reg <= {18'h0, isel_reg, 1'b0, en_reg};
            OFS_STATUS:
               prdata_reg <= {21'h0, fl.flag};
            OFS_PROT:
               prdata_reg <= {29'h0, glk_reg, lock_reg, wpd_reg};
            OFS_DATAIN:
               prdata_reg <= {24'h0, data_in_reg};
            default:
               pslverr_reg <= 1'b1;       // unmapped address
         endcase
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg & psel & penable;

   // ----------------------------------------------------------
   // software registers
   // ----------------------------------------------------------
   // global mode, enable and line routing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acpi_mode_reg <= 1'b0;
         gmgmt_en_reg  <= 1'b0;
         apic_reg      <= 1'b0;
         line_sel_reg  <= 3'h0;
      end
      else if (wr_ctrl)
      begin
         acpi_mode_reg <= pwdata[C_MODE];
         gmgmt_en_reg  <= pwdata[C_GMGMT];
         apic_reg      <= pwdata[C_APIC];
         line_sel_reg  <= pwdata[C_LINE +: 3];
      end
   end

   // per-source enables; unused positions read as zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_reg   <= '0;
         isel_reg <= 2'h0;
      end
      else if (wr_en)
      begin
         en_reg   <= pwdata[NFLAG-1:0] & EN_MASK;
         isel_reg <= pwdata[EN_ISEL +: 2];
      end
   end

   // flash protection and pin lockdown controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wpd_reg  <= 1'b0;
         lock_reg <= 1'b0;
         glk_reg  <= 1'b0;
      end
      else if (wr_prot)
      begin
         wpd_reg  <= pwdata[P_WPD];
         lock_reg <= pwdata[P_LOCK];
         glk_reg  <= pwdata[P_GLK];
      end
   end

   // data left by the OS for firmware
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data_in_reg <= 8'h00;
      else if (wr_data)
         data_in_reg <= pwdata[7:0];
   end

   // ----------------------------------------------------------
   // event detection
   // ----------------------------------------------------------
   // intrusion is a level; only its rising edge is an event
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         intr_prev_reg <= 1'b0;
      else
         intr_prev_reg <= intrusion_in;
   end

   // short eSPI pulses are ignored; one event per long hold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         espi_cnt_reg <= 16'h0000;
      else if (!espi_acpi_req)
         espi_cnt_reg <= 16'h0000;
      else if (espi_cnt_reg != 16'(ESPI_HOLD))
         espi_cnt_reg <= espi_cnt_reg + 16'h0001;
   end

   assign espi_hit  = espi_acpi_req &
                      (espi_cnt_reg == 16'(ESPI_HOLD - 1));
   assign fw_event  = (wr_prot & pwdata[P_WPD] & ~wpd_reg & lock_reg)
                    | (flash_write_attempt & ~wpd_reg);
   assign pin_event = wr_prot & ~pwdata[P_GLK] & glk_reg;
   assign nmi_hit   = nmi_event & en_reg[F_NMI];

   // ----------------------------------------------------------
   // flag set and clear
   // ----------------------------------------------------------
   always_comb
   begin
      fl.set         = '0;
      fl.set[F_TMR]  = pm_timer_wrap;
      fl.set[F_APM]  = apm_port_write;
      fl.set[F_INTR] = intrusion_in & ~intr_prev_reg;
      fl.set[F_FWW]  = fw_event;
      fl.set[F_PIN]  = pin_event;
      fl.set[F_OSW]  = wr_data;
      fl.set[F_WDG]  = nmi_hit;
      fl.set[F_NMI]  = nmi_hit;
      fl.set[F_GREL] = wr_ctrl & pwdata[C_FWREL];
      fl.set[F_BTN]  = button_override;
      fl.set[F_ESPI] = espi_hit;
   end

   // write one to clear, zeros leave flags alone
   assign fl.clr = wr_stat ? pwdata[NFLAG-1:0] : '0;

   // ----------------------------------------------------------
   // routing masks
   // ----------------------------------------------------------
   // the release event bypasses the mode bit; the button has no
   // enable of its own and never reaches the management path
   always_comb
   begin
      acpi_mask         = '0;
      acpi_mask[F_TMR]  = en_reg[F_TMR] & acpi_mode_reg;
      acpi_mask[F_BTN]  = acpi_mode_reg;
      acpi_mask[F_ESPI] = en_reg[F_ESPI] & acpi_mode_reg;
      acpi_mask[F_GREL] = en_reg[F_GREL];
   end

   always_comb
   begin
      mgmt_mask         = '0;
      mgmt_mask[F_TMR]  = en_reg[F_TMR] & ~acpi_mode_reg;
      mgmt_mask[F_ESPI] = en_reg[F_ESPI] & ~acpi_mode_reg;
      mgmt_mask[F_APM]  = en_reg[F_APM];
      mgmt_mask[F_INTR] = (isel_reg == ISEL_MGMT);
      mgmt_mask[F_FWW]  = 1'b1;
      mgmt_mask[F_PIN]  = en_reg[F_PIN];
      mgmt_mask[F_OSW]  = 1'b1;
      mgmt_mask[F_WDG]  = 1'b1;
      mgmt_mask[F_NMI]  = 1'b1;
      if (!gmgmt_en_reg)
         mgmt_mask = '0;
   end

   assign acpi_level = |(fl.flag & acpi_mask);
   assign mgmt_src   = |(fl.flag & mgmt_mask);

   // ----------------------------------------------------------
   // ACPI level interrupt and line routing
   // ----------------------------------------------------------
   // upper lines fall back to the first line outside APIC mode
   assign line_idx = ((line_sel_reg > LINE_MAX) ||
                      (line_sel_reg > LINE_LOWTOP && !apic_reg)) ?
                     3'h0 : line_sel_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acpi_irq_reg <= 1'b0;
         lines_reg    <= 7'h00;
      end
      else
      begin
         acpi_irq_reg <= acpi_level;
         lines_reg    <= acpi_level ? (7'h01 << line_idx) : 7'h00;
      end
   end

   assign acpi_event_irq = acpi_irq_reg;
   assign acpi_irq_lines = lines_reg;

   // override drops the platform to S5 straight away
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s5_reg <= 1'b0;
      else
         s5_reg <= button_override;
   end

   assign s5_entry_req = s5_reg;

   // ----------------------------------------------------------
   // management message sequencer
   // ----------------------------------------------------------
   // one message per re-arm; service software must re-arm
   assign trigger = (st_reg == ST_IDLE) & mgmt_src & rearm_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rearm_reg <= REARM_RST;
      else if (wr_ctrl && pwdata[C_REARM])
         rearm_reg <= 1'b1;
      else if (trigger)
         rearm_reg <= 1'b0;
   end

   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ST_IDLE:
            if (trigger)
               st_next = ST_SEND;
         ST_SEND:
            if (virtual_wire_message_ready)
               st_next = ST_IDLE;
         default:
            st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= ST_IDLE;
      else
         st_reg <= st_next;
   end

   assign mgmt_mode_irq = (st_reg == ST_SEND);

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_msg_needs_gen: assert property ($rose(mgmt_mode_irq) |->
      $past(gmgmt_en_reg) && $past(mgmt_src))
      else $error("message sent while management disabled");
   a_msg_clears_rearm: assert property (trigger && !wr_ctrl |=>
      mgmt_mode_irq && !rearm_reg)
      else $error("message did not consume re-arm");
   a_rearm_resend: assert property (wr_ctrl && pwdata[C_REARM] &&
      pwdata[C_GMGMT] && pwdata[C_MODE] == acpi_mode_reg &&
      st_reg == ST_IDLE && mgmt_src |=> ##1 mgmt_mode_irq)
      else $error("re-arm did not resend");
   a_acpi_mode_gate: assert property (!acpi_mode_reg &&
      !(fl.flag[F_GREL] && en_reg[F_GREL]) |=> !acpi_event_irq)
      else $error("ACPI interrupt without ACPI mode");
   a_release_sci: assert property (wr_ctrl && pwdata[C_FWREL] &&
      en_reg[F_GREL] && !wr_en |=> ##1 acpi_event_irq)
      else $error("release event gave no ACPI interrupt");
   a_acpi_level: assert property (acpi_event_irq && !acpi_level
      |=> !acpi_event_irq)
      else $error("ACPI level outlived its sources");
   a_w1c_zero: assert property (wr_stat && !pwdata[F_TMR] &&
      fl.flag[F_TMR] |=> fl.flag[F_TMR])
      else $error("flag cleared by a written 0");
   a_button_path: assert property (button_override |=>
      fl.flag[F_BTN] && s5_entry_req)
      else $error("override not recorded");
   a_espi_short: assert property (espi_hit |->
      $past(espi_acpi_req) && espi_cnt_reg == 16'(ESPI_HOLD - 1))
      else $error("short eSPI request taken");
   a_line_range: assert property (acpi_event_irq |->
      $onehot(acpi_irq_lines) &&
      (apic_reg || $past(apic_reg) || acpi_irq_lines[6:3] == 4'h0))
      else $error("ACPI line outside the allowed set");
   a_nmi_flags: assert property (nmi_event && en_reg[F_NMI] |=>
      fl.flag[F_WDG] && fl.flag[F_NMI])
      else $error("redirected NMI not recorded");

endmodule

/* File: tb/smaer_cpu_model.sv */
// Purpose: processor side taking management interrupt messages
// Assumes: message stands until ready is seen high at an edge
// Notes:   lag sets how many cycles the processor makes it wait
`timescale 1ns/1ps
module smaer_cpu_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mgmt_mode_irq,
   input  wire logic [3:0]  lag,
   output logic             ready,
   output int unsigned      msg_cnt
);
   logic [3:0] wait_reg;
   // ready for one cycle only, so a held message is counted once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready    <= 1'b0;
         wait_reg <= 4'h0;
         msg_cnt  <= 0;
      end
      else
      begin
         ready <= mgmt_mode_irq && !ready && (wait_reg >= lag);
         wait_reg <= (mgmt_mode_irq && !ready) ? wait_reg + 4'h1 : 4'h0;
         if (mgmt_mode_irq && ready)
            msg_cnt <= msg_cnt + 1;
      end
   end
endmodule

/* File: tb/tb_sys_mgmt_acpi_event_router.sv */
// Purpose: register level tests of the event router
// Assumes: zero wait APB slave, event pulses one cycle wide
// Notes:   eSPI hold shortened to 8 cycles so the run stays short
`timescale 1ns/1ps
module tb_sys_mgmt_acpi_event_router;
   import smaer_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq, mirq, rdy, s5;
   logic [6:0] lines, ev = 7'h00;
   logic [3:0] lag = 4'h0;
   int unsigned msgs, error_cnt = 0, num_checks = 0;
   always #10 pclk = ~pclk;
   smaer_top #(.ESPI_HOLD(8)) i_smaer_top (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_timer_wrap(ev[0]), .apm_port_write(ev[1]), .intrusion_in(ev[2]),
      .flash_write_attempt(ev[3]), .nmi_event(ev[4]),
      .button_override(ev[5]), .espi_acpi_req(ev[6]),
      .acpi_event_irq(irq), .acpi_irq_lines(lines), .mgmt_mode_irq(mirq),
      .virtual_wire_message_ready(rdy), .s5_entry_req(s5));
   smaer_cpu_model i_smaer_cpu_model (.pclk(pclk), .presetn(presetn),
      .mgmt_mode_irq(mirq), .lag(lag), .ready(rdy), .msg_cnt(msgs));
   // ----------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   // one APB transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk("register", rd, e);
   endtask
   // one-cycle event pulse, then let flags and the S5 request settle
   task automatic pulse(input int k);
      @(posedge pclk);
      ev <= 7'h01 << k;
      @(posedge pclk);
      ev <= 7'h00;
      #1;
   endtask
   // eSPI request held for n edges; below the hold it is ignored
   task automatic espi_hold(input int n);
      @(posedge pclk);
      ev[6] <= 1'b1;
      repeat (n) @(posedge pclk);
      ev[6] <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog: the tests need well under 20 us
   initial
   begin
      #200us;
      error_cnt++;
      close_out();
   end
   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(OFS_CTRL, 32'h4);
      rchk(OFS_STATUS, 32'h0);
      rchk(8'h20, 32'h0);
      chk("slave error", err, 1'b1);
      $display("test reset done");
      xfer(1'b1, OFS_ENABLE, 32'h102);
      xfer(1'b1, OFS_CTRL, 32'h6);
      pulse(F_APM);
      repeat (6) @(posedge pclk);
      chk("messages", msgs, 1);
      rchk(OFS_STATUS, 32'h2);
      rchk(OFS_CTRL, 32'h2);
      lag <= 4'h3;
      xfer(1'b1, OFS_CTRL, 32'h6);
      repeat (10) @(posedge pclk);
      chk("messages", msgs, 2);
      xfer(1'b1, OFS_STATUS, 32'h0);
      rchk(OFS_STATUS, 32'h2);
      xfer(1'b1, OFS_STATUS, 32'h2);
      rchk(OFS_STATUS, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h6);
      repeat (10) @(posedge pclk);
      chk("messages", msgs, 2);
      $display("test management path done");
      xfer(1'b1, OFS_CTRL, 32'h4);
      pulse(F_APM);
      repeat (10) @(posedge pclk);
      chk("messages", msgs, 2);
      xfer(1'b1, OFS_STATUS, 32'h2);
      $display("test global enable done");
      xfer(1'b1, OFS_CTRL, 32'hE);
      repeat (4) @(posedge pclk);
      chk("acpi irq", irq, 1'b1);
      chk("irq lines", lines, 7'h01);
      rchk(OFS_STATUS, 32'h100);
      xfer(1'b1, OFS_CTRL, 32'h316);
      repeat (4) @(posedge pclk);
      chk("irq lines", lines, 7'h08);
      xfer(1'b1, OFS_CTRL, 32'h306);
      repeat (4) @(posedge pclk);
      chk("irq lines", lines, 7'h01);
      xfer(1'b1, OFS_STATUS, 32'h100);
      repeat (4) @(posedge pclk);
      chk("acpi irq", irq, 1'b0);
      chk("irq lines", lines, 7'h00);
      chk("messages", msgs, 2);
      $display("test release event done");
      pulse(5);
      chk("s5 request", s5, 1'b1);
      repeat (4) @(posedge pclk);
      rchk(OFS_STATUS, 32'h200);
      chk("acpi irq", irq, 1'b0);
      xfer(1'b1, OFS_CTRL, 32'h7);
      repeat (4) @(posedge pclk);
      chk("acpi irq", irq, 1'b1);
      chk("messages", msgs, 2);
      $display("test button override done");
      xfer(1'b1, OFS_STATUS, 32'h200);
      xfer(1'b1, OFS_ENABLE, 32'h2491);
      rchk(OFS_ENABLE, 32'h2491);
      pulse(0);
      repeat (2) @(posedge pclk);
      chk("acpi irq", irq, 1'b1);
      chk("messages", msgs, 2);
      xfer(1'b1, OFS_CTRL, 32'h6);
      repeat (10) @(posedge pclk);
      chk("messages", msgs, 3);
      chk("acpi irq", irq, 1'b0);
      xfer(1'b1, OFS_STATUS, 32'h1);
      $display("test timer routing done");
      pulse(2);
      pulse(3);
      pulse(4);
      rchk(OFS_STATUS, 32'hCC);
      xfer(1'b1, OFS_STATUS, 32'h8);
      xfer(1'b1, OFS_PROT, 32'h6);
      xfer(1'b1, OFS_PROT, 32'h3);
      xfer(1'b1, OFS_DATAIN, 32'h5A);
      rchk(OFS_DATAIN, 32'h5A);
      rchk(OFS_STATUS, 32'hFC);
      chk("messages", msgs, 3);
      xfer(1'b1, OFS_CTRL, 32'h6);
      repeat (10) @(posedge pclk);
      chk("messages", msgs, 4);
      xfer(1'b1, OFS_STATUS, 32'hFC);
      $display("test management sources done");
      xfer(1'b1, OFS_CTRL, 32'h7);
      espi_hold(7);
      rchk(OFS_STATUS, 32'h0);
      espi_hold(8);
      rchk(OFS_STATUS, 32'h400);
      chk("acpi irq", irq, 1'b1);
      chk("messages", msgs, 4);
      $display("test eSPI request done");
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rchk(OFS_CTRL, 32'h4);
      rchk(OFS_STATUS, 32'h0);
      chk("acpi irq", irq, 1'b0);
      $display("test second reset done");
      close_out();
   end
endmodule
